// ===== design/autotune_pkg.sv
// Shared constants, codes and carrier types for the limit-cycle auto-tuning sequencer.
// Assumes one 40 MHz clock domain; all configuration arrives as same-clock logic levels.
package autotune_pkg;

  // Data widths
  localparam int PV_W   = 16;
  localparam int SPAN_W = 32;

  // Drive levels in 0.01 % steps
  localparam logic [15:0] DRIVE_FULL = 16'h2710;  // 100.00 %
  localparam logic [15:0] DRIVE_ZERO = 16'h0000;  // 0 %

  // Tune request codes
  localparam logic [2:0] REQ_NONE      = 3'h0;
  localparam logic [2:0] REQ_GROUP_MIN = 3'h1;
  localparam logic [2:0] REQ_ALL       = 3'h5;

  // Control kind, run/stop and auto/manual/cascade codes
  localparam logic [1:0] KIND_ONOFF    = 2'h1;
  localparam logic [1:0] KIND_HC_ONOFF = 2'h3;
  localparam logic       RUN_STOP_STOP = 1'h0;
  localparam logic [1:0] AMC_AUTO      = 2'h0;
  localparam logic [1:0] AMC_MANUAL    = 2'h1;
  localparam logic [1:0] AMC_CASCADE   = 2'h2;

  // Tuning point clamp, percent of input range
  localparam logic [7:0] CLAMP_LO_PCT = 8'h03;
  localparam logic [7:0] CLAMP_HI_PCT = 8'h61;
  localparam logic [7:0] PCT_SCALE    = 8'h64;

  // Peaks to the end of one oscillation measurement
  localparam logic [1:0] PEAK_LAST_IDX = 2'h2;  // third peak completes when two are counted
  localparam logic [1:0] GROUP_LAST    = 2'h3;
  localparam logic [1:0] GROUP_FIRST   = 2'h0;

  // Session time limit
  localparam longint unsigned TIMEOUT_HOURS   = 64'd24;
  localparam longint unsigned CLK_HZ          = 64'd40_000_000;
  localparam longint unsigned SEC_PER_HOUR    = 64'd3600;
  localparam logic [47:0]     TIMEOUT_CYCLES  = 48'(TIMEOUT_HOURS * SEC_PER_HOUR * CLK_HZ);
  localparam logic [15:0]     COOL_FACTOR_DEF = 16'h0064;  // 1.00 in 0.01 steps

  // Reset values
  localparam logic [47:0] TIMER_RST = 48'h0;
  localparam logic [2:0]  REQ_RST   = 3'h0;

  typedef enum logic [1:0] {
    ROLE_SOLO      = 2'b00,
    ROLE_PRIMARY   = 2'b01,
    ROLE_SECONDARY = 2'b10
  } loop_role_t;

  typedef enum logic [1:0] {
    OUT_NORMAL    = 2'b00,
    OUT_RUNNING   = 2'b01,
    OUT_HOST_STOP = 2'b10,
    OUT_ERROR     = 2'b11
  } tune_outcome_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RUN   = 2'b01,
    ST_STORE = 2'b10
  } tune_state_t;

  typedef struct packed {
    logic [1:0] control_kind_select;
    logic       run_stop_select;
    logic [1:0] amc_select;
    loop_role_t role;
    logic       remote_local_select;  // 1 = remote
    logic       drive_time_prop;      // 1 = time-proportional, 0 = continuous
    logic       banded_enable;
  } loop_cfg_t;

  typedef struct packed {
    logic [PV_W-1:0] range_low;
    logic [PV_W-1:0] range_high;
    logic [PV_W-1:0] first_reference_point;
    logic [PV_W-1:0] second_reference_point;
  } range_set_t;

  typedef struct packed {
    logic [15:0]       proportional_band;
    logic [SPAN_W-1:0] integral_span;
    logic [SPAN_W-1:0] derivative_span;
    logic [15:0]       cooling_factor;
  } gain_set_t;

endpackage

// ===== design/peak_tracker.sv
// Oscillation peak tracker for the limit-cycle tuner.
// Assumes measured value and tuning point are same-clock values held stable while enabled.
`timescale 1ns/10ps
`default_nettype none
module peak_tracker #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_reset_n,
  // Control
  input  wire logic                 i_clear,
  input  wire logic [W-1:0]         i_measured_value,
  input  wire logic [W-1:0]         i_point,
  // Results
  output logic                      o_third_peak,
  output logic [W-1:0]              o_peak_max,
  output logic [W-1:0]              o_peak_min,
  output logic [31:0]               o_period
);

  initial begin
    if (W < 2 || W > 32) $error("peak_tracker: W out of range");
  end

  logic          above;
  logic          above_r;
  logic          seen_r;
  logic          crossed_r;
  logic          crossing;
  logic [1:0]    peaks_r;
  logic [W-1:0]  ext_r;
  logic [31:0]   cyc_r;

  assign above    = (i_measured_value >= i_point);
  assign crossing = seen_r && (above != above_r);

  // Side of the tuning point and first crossing seen
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || i_clear) begin
      above_r   <= 1'b0;
      seen_r    <= 1'b0;
      crossed_r <= 1'b0;
    end else begin
      above_r <= above;
      seen_r  <= 1'b1;
      if (crossing) crossed_r <= 1'b1;
    end
  end

  // Extreme since the last crossing; a peak closes at the next crossing
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || i_clear) begin
      ext_r <= '0;
    end else if (crossing || !seen_r) begin
      ext_r <= i_measured_value;
    end else if (above_r ? (i_measured_value > ext_r) : (i_measured_value < ext_r)) begin
      ext_r <= i_measured_value;  // R19
    end
  end

  // Peak count, recorded extremes and full-period timing from first to third peak
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || i_clear) begin
      peaks_r      <= 2'h0;
      o_peak_max   <= '0;
      o_peak_min   <= '0;
      o_period     <= 32'h0;
      o_third_peak <= 1'b0;
      cyc_r        <= 32'h0;
    end else begin
      o_third_peak <= 1'b0;
      if (cyc_r != 32'hffff_ffff) cyc_r <= cyc_r + 32'h1;  // Saturates on very slow plants
      if (crossing && crossed_r) begin
        if (above_r) o_peak_max <= ext_r;
        else         o_peak_min <= ext_r;
        if (peaks_r == 2'h0) cyc_r <= 32'h0;
        if (peaks_r == autotune_pkg::PEAK_LAST_IDX) begin
          o_third_peak <= 1'b1;  // R19
          o_period     <= cyc_r;
        end else begin
          peaks_r <= peaks_r + 2'h1;
        end
      end
    end
  end

endmodule // peak_tracker
`default_nettype wire

// ===== design/pid_limit_cycle_autotune.sv
// Limit-cycle auto-tuning sequencer for one control loop.
// Assumes all inputs come from logic on i_ref_clk; the host-side request code is a held level.
// Summary of operation
// R01 - Writing request code 1 to 5 starts tuning; other codes never start it.
// R02 - Drive toggles between on and off level as measured value crosses tuning point.
// R03 - At the third peak gains are computed, stored in the group, session ends unless code 5 has groups left.
// R04 - Continuous drive uses drive ceiling and drive floor as on and off levels.
// R05 - Time-proportional drive uses 100 % on and 0 % off, ignoring limits.
// R06 - No start while control kind is on/off (1) or heating/cooling on/off (3).
// R07 - No start while run/stop holds stop (0).
// R08 - No start for disallowed auto/manual/cascade selection of loop role.
// R09 - Inhibit, power loss, setup mode, sensor fault or code 0 aborts a session.
// R10 - A session still running after 24 hours aborts as error exit.
// R11 - Done flag is 1 while code is 0 and 0 while code is 1 to 5.
// R12 - Outcome is 0 normal, 1 running, 2 host stopped, 3 error exit.
// R13 - Sensor fault, timeout, stop or bad auto/manual/cascade setting gives outcome 3.
// R14 - Codes 1 to 4 tune one group at its target; code 5 tunes all four.
// R15 - Banded tuning with code 5 uses reference-point midpoints as tuning points.
// R16 - Success overwrites band, integral span, derivative span and cooling factor.
// R17 - Every tuning point is clamped to 3 % .. 97 % of the input range.
// R18 - Remote selection uses the remote target as tuning point.
// R19 - Peaks are extremes between consecutive crossings, counted to the third.
// R20 - Outcome goes to 1 at a valid start; the final value then holds until setup mode while idle resets it to 0.
`timescale 1ns/10ps
`default_nettype none
module pid_limit_cycle_autotune #(
  parameter logic [47:0] TIMEOUT_CYCLES = autotune_pkg::TIMEOUT_CYCLES,
  parameter logic [15:0] COOL_FACTOR    = autotune_pkg::COOL_FACTOR_DEF
) (
  // Clock and reset
  input  wire logic                                 i_ref_clk,
  input  wire logic                                 i_reset_n,
  // Host request and mode
  input  wire logic [2:0]                           i_tune_request_code,
  input  wire logic                                 i_setup_mode,
  input  wire logic                                 i_power_fail,
  input  wire logic                                 i_sensor_fault,
  // Loop configuration
  input  wire autotune_pkg::loop_cfg_t              i_loop_cfg,
  input  wire autotune_pkg::range_set_t             i_range,
  input  wire logic [3:0][autotune_pkg::PV_W-1:0]   i_target_value,
  input  wire logic [autotune_pkg::PV_W-1:0]        i_remote_target,
  input  wire logic [15:0]                          i_drive_ceiling,
  input  wire logic [15:0]                          i_drive_floor,
  // Process
  input  wire logic [autotune_pkg::PV_W-1:0]        i_measured_value,
  // Drive and status
  output logic [15:0]                               o_drive_level,
  output logic                                      o_tuning_active,
  output logic                                      o_tuning_done_flag,
  output autotune_pkg::tune_outcome_t               o_tune_outcome_code,
  output logic                                      o_request_clear,
  // Gain group write
  output logic                                      o_gain_write,
  output logic [1:0]                                o_gain_group,
  output autotune_pkg::gain_set_t                   o_gains
);

  localparam int PW = autotune_pkg::PV_W;

  initial begin
    if (TIMEOUT_CYCLES == 48'h0) $error("pid_limit_cycle_autotune: TIMEOUT_CYCLES must be nonzero");
  end

  autotune_pkg::tune_state_t state_r;
  autotune_pkg::tune_state_t state_nxt;
  logic [1:0]         group_r;
  logic               all_mode_r;
  logic [2:0]         req_q_r;
  logic [47:0]        timer_r;
  logic               req_valid;
  logic               inhibit;
  logic               amc_bad;
  logic               start;
  logic               third_peak;
  logic [PW-1:0]      peak_max;
  logic [PW-1:0]      peak_min;
  logic [31:0]        period;
  logic [PW-1:0]      span;
  logic [PW+7:0]      lo_prod;
  logic [PW+7:0]      hi_prod;
  logic [PW-1:0]      clamp_lo;
  logic [PW-1:0]      clamp_hi;
  logic [PW-1:0]      raw_point;
  logic [PW-1:0]      point;
  logic [3:0][PW-1:0] band_mid;
  logic [15:0]        on_level;
  logic [15:0]        off_level;
  logic               abort_quiet;
  logic               abort_error;
  logic               abort_host;

  // Request decode and start qualification
  assign req_valid = (i_tune_request_code >= autotune_pkg::REQ_GROUP_MIN) &&
                     (i_tune_request_code <= autotune_pkg::REQ_ALL);  // R01

  // Auto/manual/cascade legality depends on the loop's role in a cascade
  always_comb begin
    amc_bad = 1'b0;
    if (i_loop_cfg.role == autotune_pkg::ROLE_PRIMARY)
      amc_bad = (i_loop_cfg.amc_select != autotune_pkg::AMC_CASCADE);  // R08
    else if (i_loop_cfg.role == autotune_pkg::ROLE_SECONDARY)
      amc_bad = (i_loop_cfg.amc_select != autotune_pkg::AMC_AUTO);  // R08
    else
      amc_bad = (i_loop_cfg.amc_select == autotune_pkg::AMC_MANUAL);  // R08
  end

  // Any inhibit condition both refuses a start and ends a running session
  assign inhibit = (i_loop_cfg.control_kind_select == autotune_pkg::KIND_ONOFF) ||    // R06
                   (i_loop_cfg.control_kind_select == autotune_pkg::KIND_HC_ONOFF) || // R06
                   (i_loop_cfg.run_stop_select == autotune_pkg::RUN_STOP_STOP) ||     // R07
                   amc_bad;

  // Only a fresh request starts; a held code after completion does not retrigger
  assign start = (state_r == autotune_pkg::ST_IDLE) && req_valid && (req_q_r == autotune_pkg::REQ_NONE) &&
                 !inhibit && !i_setup_mode && !i_power_fail && !i_sensor_fault;

  // Abort causes in priority order: power and setup are silent, faults are errors
  assign abort_quiet = i_power_fail || i_setup_mode;  // R09
  assign abort_error = i_sensor_fault || inhibit || (timer_r >= TIMEOUT_CYCLES);  // R09 R10 R13
  assign abort_host  = (i_tune_request_code == autotune_pkg::REQ_NONE);  // R09

  // Clamp window of 3 % .. 97 % of the input range
  assign span     = i_range.range_high - i_range.range_low;
  assign lo_prod  = (PW + 8)'(span) * (PW + 8)'(autotune_pkg::CLAMP_LO_PCT);
  assign hi_prod  = (PW + 8)'(span) * (PW + 8)'(autotune_pkg::CLAMP_HI_PCT);
  assign clamp_lo = i_range.range_low + PW'(lo_prod / (PW + 8)'(autotune_pkg::PCT_SCALE));
  assign clamp_hi = i_range.range_low + PW'(hi_prod / (PW + 8)'(autotune_pkg::PCT_SCALE));

  // Banded tuning points as midpoints; widened sums so the halves never wrap
  assign band_mid[0] = PW'(({1'b0, i_range.range_low} + {1'b0, i_range.first_reference_point}) >> 1);
  assign band_mid[1] = PW'(({1'b0, i_range.first_reference_point} +
                            {1'b0, i_range.second_reference_point}) >> 1);
  assign band_mid[2] = PW'(({1'b0, i_range.second_reference_point} + {1'b0, i_range.range_high}) >> 1);
  assign band_mid[3] = PW'(({1'b0, i_range.range_low} + {1'b0, i_range.range_high}) >> 1);

  // Tuning point selection: remote first, then banded, then the numbered target
  always_comb begin
    if (i_loop_cfg.remote_local_select)
      raw_point = i_remote_target;  // R18
    else if (i_loop_cfg.banded_enable && all_mode_r)
      raw_point = band_mid[group_r];  // R15
    else
      raw_point = i_target_value[group_r];  // R14
    if (raw_point < clamp_lo)      point = clamp_lo;  // R17
    else if (raw_point > clamp_hi) point = clamp_hi;  // R17
    else                           point = raw_point;
  end

  // Oscillation levels depend on the drive kind
  assign on_level  = i_loop_cfg.drive_time_prop ? autotune_pkg::DRIVE_FULL : i_drive_ceiling;  // R04 R05
  assign off_level = i_loop_cfg.drive_time_prop ? autotune_pkg::DRIVE_ZERO : i_drive_floor;    // R04 R05

  // The tracker restarts whenever the sequencer is not oscillating a group
  peak_tracker #(
    .W (PW)
  ) u_peak (
    .i_ref_clk        (i_ref_clk),
    .i_reset_n        (i_reset_n),
    .i_clear          (state_r != autotune_pkg::ST_RUN),
    .i_measured_value (i_measured_value),
    .i_point          (point),
    .o_third_peak     (third_peak),
    .o_peak_max       (peak_max),
    .o_peak_min       (peak_min),
    .o_period         (period)
  );

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      autotune_pkg::ST_IDLE: begin
        if (start) state_nxt = autotune_pkg::ST_RUN;  // R01
      end
      autotune_pkg::ST_RUN: begin
        if (abort_quiet || abort_error || abort_host) state_nxt = autotune_pkg::ST_IDLE;  // R09
        else if (third_peak)                          state_nxt = autotune_pkg::ST_STORE;  // R03
      end
      autotune_pkg::ST_STORE: begin
        if (all_mode_r && group_r != autotune_pkg::GROUP_LAST) state_nxt = autotune_pkg::ST_RUN;  // R14
        else                                                   state_nxt = autotune_pkg::ST_IDLE;  // R03
      end
      default: state_nxt = autotune_pkg::ST_IDLE;
    endcase
  end

  // State, request history and group selection
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      state_r    <= autotune_pkg::ST_IDLE;
      req_q_r    <= autotune_pkg::REQ_RST;
      group_r    <= autotune_pkg::GROUP_FIRST;
      all_mode_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_q_r <= i_tune_request_code;
      if (start) begin
        all_mode_r <= (i_tune_request_code == autotune_pkg::REQ_ALL);  // R14
        group_r    <= (i_tune_request_code == autotune_pkg::REQ_ALL) ? autotune_pkg::GROUP_FIRST :
                      2'(i_tune_request_code - autotune_pkg::REQ_GROUP_MIN);  // R14
      end else if (state_r == autotune_pkg::ST_STORE && state_nxt == autotune_pkg::ST_RUN) begin
        group_r <= group_r + 2'h1;  // R14
      end
    end
  end

  // Session timer runs across all groups of one request
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || start) begin
      timer_r <= autotune_pkg::TIMER_RST;
    end else if (state_r != autotune_pkg::ST_IDLE && timer_r < TIMEOUT_CYCLES) begin
      timer_r <= timer_r + 48'h1;  // R10
    end
  end

  // Outcome code; the final value holds until the next start or until setup mode while idle resets it to 0
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_tune_outcome_code <= autotune_pkg::OUT_NORMAL;  // R12
    end else if (start) begin
      o_tune_outcome_code <= autotune_pkg::OUT_RUNNING;  // R20
    end else if (state_r == autotune_pkg::ST_IDLE && i_setup_mode) begin
      o_tune_outcome_code <= autotune_pkg::OUT_NORMAL;  // R12
    end else if (state_r == autotune_pkg::ST_RUN) begin
      if (abort_quiet)      o_tune_outcome_code <= autotune_pkg::OUT_NORMAL;     // R12
      else if (abort_error) o_tune_outcome_code <= autotune_pkg::OUT_ERROR;      // R13
      else if (abort_host)  o_tune_outcome_code <= autotune_pkg::OUT_HOST_STOP;  // R12
    end else if (state_r == autotune_pkg::ST_STORE && state_nxt == autotune_pkg::ST_IDLE) begin
      o_tune_outcome_code <= autotune_pkg::OUT_NORMAL;  // R12 R20
    end
  end

  // Drive output: reverse action, on below the point and off at or above it
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_drive_level   <= autotune_pkg::DRIVE_ZERO;
      o_tuning_active <= 1'b0;
    end else begin
      o_tuning_active <= (state_nxt != autotune_pkg::ST_IDLE);
      if (state_r == autotune_pkg::ST_RUN && state_nxt == autotune_pkg::ST_RUN)
        o_drive_level <= (i_measured_value < point) ? on_level : off_level;  // R02 R04 R05
      else
        o_drive_level <= autotune_pkg::DRIVE_ZERO;
    end
  end

  // Done flag follows the request code; the host may interrupt on its rising edge
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_tuning_done_flag <= 1'b1;
    end else begin
      o_tuning_done_flag <= !req_valid;  // R11
    end
  end

  // Gain computation from the measured cycle; spans follow the classic period ratios
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_gain_write    <= 1'b0;
      o_gain_group    <= autotune_pkg::GROUP_FIRST;
      o_gains         <= '0;
      o_request_clear <= 1'b0;
    end else begin
      o_gain_write    <= 1'b0;
      o_request_clear <= 1'b0;
      if (state_r == autotune_pkg::ST_RUN && state_nxt == autotune_pkg::ST_STORE) begin
        o_gain_write              <= 1'b1;  // R03
        o_gain_group              <= group_r;  // R16
        o_gains.proportional_band <= 16'(peak_max - peak_min);  // R16
        o_gains.integral_span     <= period >> 1;  // R16
        o_gains.derivative_span   <= period >> 3;  // R16
        o_gains.cooling_factor    <= COOL_FACTOR;  // R16
      end
      if (state_r == autotune_pkg::ST_STORE && state_nxt == autotune_pkg::ST_IDLE)
        o_request_clear <= 1'b1;  // R03
    end
  end

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  a_refuse_kind: assert property ((state_r == autotune_pkg::ST_IDLE) &&  // R06
      (i_loop_cfg.control_kind_select == autotune_pkg::KIND_ONOFF ||
       i_loop_cfg.control_kind_select == autotune_pkg::KIND_HC_ONOFF) |=> state_r == autotune_pkg::ST_IDLE)
    else $error("start accepted with on/off control kind");
  a_refuse_stop: assert property ((state_r == autotune_pkg::ST_IDLE) &&  // R07
      (i_loop_cfg.run_stop_select == autotune_pkg::RUN_STOP_STOP) |=> !o_tuning_active)
    else $error("start accepted while stopped");
  a_refuse_amc: assert property ((state_r == autotune_pkg::ST_IDLE) && amc_bad  // R08
      |=> o_tune_outcome_code != autotune_pkg::OUT_RUNNING)
    else $error("start accepted with bad auto/manual/cascade");
  a_start_runs: assert property ($rose(req_valid) && start  // R01 R20
      |=> o_tune_outcome_code == autotune_pkg::OUT_RUNNING && o_tuning_active && !o_tuning_done_flag)
    else $error("valid start did not begin session");
  a_host_stop: assert property ((state_r == autotune_pkg::ST_RUN) && abort_host && !abort_quiet && !abort_error  // R09
      |=> o_tune_outcome_code == autotune_pkg::OUT_HOST_STOP ##1 !o_tuning_active)
    else $error("host stop not reported");
  a_error_exit: assert property ((state_r == autotune_pkg::ST_RUN) && i_sensor_fault && !abort_quiet  // R13
      |=> o_tune_outcome_code == autotune_pkg::OUT_ERROR && state_r == autotune_pkg::ST_IDLE)
    else $error("fault did not give error exit");
  a_done_follow: assert property ($changed(req_valid) |=> o_tuning_done_flag == !$past(req_valid))  // R11
    else $error("done flag does not follow request");
  a_drive_prop: assert property ((state_r == autotune_pkg::ST_RUN) && i_loop_cfg.drive_time_prop  // R05
      && $stable(state_r) && o_drive_level != autotune_pkg::DRIVE_ZERO |-> o_drive_level == autotune_pkg::DRIVE_FULL)
    else $error("time-proportional drive level wrong");
  a_point_clamp: assert property ((state_r == autotune_pkg::ST_RUN) |-> point >= clamp_lo && point <= clamp_hi)  // R17
    else $error("tuning point outside clamp window");
  a_store_group: assert property (third_peak && (state_r == autotune_pkg::ST_RUN) && !abort_quiet && !abort_error  // R03
      && !abort_host |=> o_gain_write && o_gain_group == $past(group_r) ##1 !o_gain_write)
    else $error("third peak did not store gains");
  a_all_advance: assert property ((state_r == autotune_pkg::ST_STORE) && all_mode_r  // R14
      && group_r != autotune_pkg::GROUP_LAST |=> state_r == autotune_pkg::ST_RUN && group_r == $past(group_r) + 2'h1)
    else $error("all-group request did not advance");
  a_timeout_end: assert property ((state_r == autotune_pkg::ST_RUN) && (timer_r >= TIMEOUT_CYCLES)  // R10
      && !abort_quiet |=> o_tune_outcome_code == autotune_pkg::OUT_ERROR)
    else $error("timeout did not end session");

  c_start: cover property (start);
  c_store: cover property (o_gain_write);
  c_host_stop: cover property (o_tune_outcome_code == autotune_pkg::OUT_HOST_STOP);
  c_all_last: cover property (o_gain_write && o_gain_group == autotune_pkg::GROUP_LAST);

endmodule // pid_limit_cycle_autotune
`default_nettype wire

// ===== tb/pid_limit_cycle_autotune_test.sv
// Self-checking bench for the auto-tuning sequencer.
// Assumes the plant model closes the loop; short timeout parameter.
`timescale 1ns/10ps
`default_nettype none
module pid_limit_cycle_autotune_test;
  logic i_ref_clk = 1'b0, i_reset_n = 1'b0, i_setup_mode = 1'b0, i_power_fail = 1'b0, i_sensor_fault = 1'b0;
  logic [2:0] code = 3'h0;
  autotune_pkg::loop_cfg_t cfg = '0;
  logic [15:0] pv, drive;
  logic act, done, wr, clr;
  logic [1:0] grp, outc;
  int num_errors = 0, checked = 0, cycles = 0;
  // Half period of 12.5 ns gives 40 MHz
  always #12.5 i_ref_clk = ~i_ref_clk;
  pid_limit_cycle_autotune #(.TIMEOUT_CYCLES(48'h7d0)) uut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_tune_request_code(code), .i_setup_mode(i_setup_mode), .i_power_fail(i_power_fail),
    .i_sensor_fault(i_sensor_fault), .i_loop_cfg(cfg), .i_range({16'h0, 16'hffff, 16'h4000, 16'h8000}),
    .i_target_value({4{16'h1000}}), .i_remote_target(16'h1000), .i_drive_ceiling(16'h2000),
    .i_drive_floor(16'h0), .i_measured_value(pv), .o_drive_level(drive), .o_tuning_active(act),
    .o_tuning_done_flag(done), .o_tune_outcome_code(outc), .o_request_clear(clr),
    .o_gain_write(wr), .o_gain_group(grp), .o_gains());
  plant_model plant (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_drive_level(drive), .o_measured_value(pv));
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #2;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog against a hung handshake
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    cfg.run_stop_select = 1'b1;
    step(12);
    i_reset_n = 1'b1;
    step(1);
    chk(done, 1'b1);
    chk(outc, autotune_pkg::OUT_NORMAL);
    // On/off control kind must not start
    cfg.control_kind_select = autotune_pkg::KIND_ONOFF;
    code = 3'h1;
    step(4);
    chk(act, 1'b0);
    code = 3'h0;
    cfg.control_kind_select = 2'h0;
    step(2);
    // Normal session on group two
    code = 3'h2;
    step(2);
    chk(outc, autotune_pkg::OUT_RUNNING);
    chk(done, 1'b0);
    chk(drive, 16'h2000);
    for (int i = 0; i < 300 && wr !== 1'b1; i++) step(1);
    chk(wr, 1'b1);
    chk(grp, 2'h1);
    step(1);
    chk(clr, 1'b1);
    step(1);
    chk(clr, 1'b0);
    chk(outc, autotune_pkg::OUT_NORMAL);
    code = 3'h0;
    step(3);
    // Host stop then sensor fault
    code = 3'h1;
    step(3);
    code = 3'h0;
    step(3);
    chk(outc, autotune_pkg::OUT_HOST_STOP);
    code = 3'h3;
    step(3);
    i_sensor_fault = 1'b1;
    step(3);
    chk(outc, autotune_pkg::OUT_ERROR);
    chk(act, 1'b0);
    // Time-proportional drive, then power loss ends the session quietly
    i_sensor_fault = 1'b0;
    code = 3'h0;
    cfg.drive_time_prop = 1'b1;
    step(20);
    code = 3'h4;
    step(2);
    chk(outc, autotune_pkg::OUT_RUNNING);
    chk(drive, autotune_pkg::DRIVE_FULL);
    i_power_fail = 1'b1;
    step(2);
    chk(outc, autotune_pkg::OUT_NORMAL);
    chk(act, 1'b0);
    summarize();
  end
endmodule // pid_limit_cycle_autotune_test
`default_nettype wire

// ===== tb/plant_model.sv
// Plant model: measured value ramps while the drive is on.
// Assumes a zero drive level means the heater is off.
`timescale 1ns/10ps
`default_nettype none
module plant_model (
  // Clock, reset, drive and measurement
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic [15:0] i_drive_level,
  output logic      [15:0] o_measured_value
);
  // Steps of 4 a cycle, so every crossing overshoots and peaks appear
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) o_measured_value <= 16'h0f00;
    else if (i_drive_level != 16'h0) o_measured_value <= o_measured_value + 16'h4;
    else o_measured_value <= o_measured_value - 16'h4;
  end
endmodule // plant_model
`default_nettype wire
